// ---- rtl/aar_pkg.sv ----
// ----------------------------------------------------------------------------
// Alarm register bank constants
// ----------------------------------------------------------------------------
package aar_pkg;

   // ----------------------------------------------------------------------------
   // Register byte offsets on the Wishbone bus
   // ----------------------------------------------------------------------------
   localparam logic [7:0] ALARM_STATUS_OFS = 8'h20;
   localparam logic [7:0] HIGH_TH_OFS      = 8'h24;
   localparam logic [7:0] LOW_TH_OFS       = 8'h28;
   localparam logic [7:0] IRQ_STATUS_OFS   = 8'h30;
   localparam logic [7:0] IRQ_CLEAR_OFS    = 8'h34;
   localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h38;

   // ----------------------------------------------------------------------------
   // Flag vector layout (tripped flags, interrupt status and enable)
   // ----------------------------------------------------------------------------
   localparam int NUM_FLAGS         = 4;
   localparam int FLAG_INPUT_HIGH   = 0;
   localparam int FLAG_INPUT_LOW    = 1;
   localparam int FLAG_SUPPLY_HIGH  = 2;
   localparam int FLAG_SUPPLY_LOW   = 3;

   // ----------------------------------------------------------------------------
   // Alarm status field positions
   // ----------------------------------------------------------------------------
   localparam int ACT_SUPPLY_LOW_BIT   = 15;
   localparam int ACT_SUPPLY_HIGH_BIT  = 14;
   localparam int ACT_INPUT_LOW_BIT    = 11;
   localparam int ACT_INPUT_HIGH_BIT   = 10;
   localparam int LAT_SUPPLY_LOW_BIT   = 7;
   localparam int LAT_SUPPLY_HIGH_BIT  = 6;
   localparam int LAT_INPUT_LOW_BIT    = 5;
   localparam int LAT_INPUT_HIGH_BIT   = 4;
   localparam int OVERALL_BIT          = 0;

   // ----------------------------------------------------------------------------
   // Threshold register fields and reset values
   // ----------------------------------------------------------------------------
   localparam int HYST_LSB             = 24;
   localparam int HYST_USED_LSB        = 6;
   localparam int TH_CMP_LSB           = 4;
   localparam logic [7:0]  HYST_RST    = 8'h00;
   localparam logic [15:0] HIGH_TH_RST = 16'hffff;
   localparam logic [15:0] LOW_TH_RST  = 16'h0000;
   localparam logic [31:0] STATUS_RST  = 32'h0000_0000;

endpackage : aar_pkg

// ---- rtl/aar_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage level synchroniser
// ----------------------------------------------------------------------------
module aar_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : aar_sync

`default_nettype wire

// ---- rtl/aar_flag.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Sticky flag vector, set wins over clear
// ----------------------------------------------------------------------------
module aar_flag #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clear_i,
   output var  logic [WIDTH-1:0] flag_o
);

   logic [WIDTH-1:0] next_flag;

   // An event in the clearing cycle must not be lost
   always_comb begin
      next_flag = (flag_o & ~clear_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_o <= '0;
      end else begin
         flag_o <= next_flag;
      end
   end

endmodule : aar_flag

`default_nettype wire

// ---- rtl/aar_top.sv ----
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bit 15 shows live supply-low condition
// - Bit 14 shows live supply-high condition
// - Bits 11,10 show live input alarm flags
// - Bits 7,6 latch supply low/high alarms
// - Bits 5,4 latch input alarm flags
// - Bit 0 is OR of latched flags
// - Status read-only, zero reset, reserved zero
// - Hysteresis byte bits 31-24, top two used
// - High threshold resets FFFFh, compares [15:4]
// - Low threshold resets 0000h, compares [15:4]
// - Status register at byte 20h-23h
// - High threshold at 24h-27h, 23-16 zero
// - Low threshold at 28h-2Bh, upper half zero
module aar_top #(
   parameter int ADDR_W = 8,
   parameter int CODE_W = 12
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output var  logic [31:0]       wb_dat_o,
   output var  logic              wb_ack_o,
   input  wire logic [CODE_W-1:0] conv_data_i,
   input  wire logic              conv_valid_i,
   input  wire logic              supply_low_i,
   input  wire logic              supply_high_i,
   output var  logic              overall_alarm_o,
   output var  logic              irq_o
);

   localparam int NF = aar_pkg::NUM_FLAGS;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic [1:0]        supply_sync;
   logic              act_supply_low;
   logic              act_supply_high;
   logic              act_input_high;
   logic              act_input_low;
   logic              next_act_input_high;
   logic              next_act_input_low;
   logic [NF-1:0]     active_vec;
   logic [NF-1:0]     active_prev;
   logic [NF-1:0]     tripped;
   logic [NF-1:0]     trip_clear;
   logic [NF-1:0]     irq_status;
   logic [NF-1:0]     irq_set;
   logic [NF-1:0]     irq_clear;
   logic [NF-1:0]     irq_enable;
   logic [NF-1:0]     next_irq_enable;
   logic [7:0]        hyst_byte;
   logic [7:0]        next_hyst_byte;
   logic [15:0]       high_th;
   logic [15:0]       next_high_th;
   logic [15:0]       low_th;
   logic [15:0]       next_low_th;
   logic              take;
   logic              take_wr;
   logic              take_rd;
   logic [ADDR_W-1:0] word_adr;
   logic [31:0]       status_word;
   logic [31:0]       next_dat;
   logic              next_ack;
   logic              next_overall;
   logic              next_irq;
   logic [CODE_W-1:0] th_hi_cmp;
   logic [CODE_W-1:0] th_lo_cmp;
   logic [1:0]        hyst_val;
   logic [CODE_W:0]   code_plus_hyst;
   logic [CODE_W:0]   lo_plus_hyst;

   // ----------------------------------------------------------------------------
   // Supply comparators arrive from the analog side
   // ----------------------------------------------------------------------------
   // Pins are asynchronous; two flops before any logic reads them
   aar_sync #(
      .WIDTH   (2)
   ) u_supply_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({supply_high_i, supply_low_i}),
      .sync_o  (supply_sync)
   );

   // Live supply conditions follow the synchronised pins
   assign act_supply_low  = supply_sync[0];
   assign act_supply_high = supply_sync[1];

   // ----------------------------------------------------------------------------
   // Input window comparison
   // ----------------------------------------------------------------------------
   // Only the upper twelve threshold bits take part
   assign th_hi_cmp      = high_th[15:aar_pkg::TH_CMP_LSB];
   assign th_lo_cmp      = low_th[15:aar_pkg::TH_CMP_LSB];
   assign hyst_val       = hyst_byte[7:aar_pkg::HYST_USED_LSB];
   assign code_plus_hyst = {1'b0, conv_data_i} + {{(CODE_W - 1){1'b0}}, hyst_val};
   assign lo_plus_hyst   = {1'b0, th_lo_cmp} + {{(CODE_W - 1){1'b0}}, hyst_val};

   // Set past the threshold; release only once back by the hysteresis.
   // Flags change only on a fresh conversion, so a stale code never moves them.
   always_comb begin
      next_act_input_high = act_input_high;
      next_act_input_low  = act_input_low;
      if (conv_valid_i) begin
         if (act_input_high) begin
            next_act_input_high = code_plus_hyst > {1'b0, th_hi_cmp};
         end else begin
            next_act_input_high = conv_data_i > th_hi_cmp;
         end
         if (act_input_low) begin
            next_act_input_low = {1'b0, conv_data_i} < lo_plus_hyst;
         end else begin
            next_act_input_low = conv_data_i < th_lo_cmp;
         end
      end
   end

   // Live input flags start quiet after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_input_high <= 1'b0;
         act_input_low  <= 1'b0;
      end else begin
         act_input_high <= next_act_input_high;
         act_input_low  <= next_act_input_low;
      end
   end

   // ----------------------------------------------------------------------------
   // Live flag vector and edge history
   // ----------------------------------------------------------------------------
   // One bit order shared by latched, interrupt and enable vectors
   always_comb begin
      active_vec                            = '0;
      active_vec[aar_pkg::FLAG_INPUT_HIGH]  = act_input_high;
      active_vec[aar_pkg::FLAG_INPUT_LOW]   = act_input_low;
      active_vec[aar_pkg::FLAG_SUPPLY_HIGH] = act_supply_high;
      active_vec[aar_pkg::FLAG_SUPPLY_LOW]  = act_supply_low;
   end

   // History idles at zero, so no false onset follows reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_prev <= '0;
      end else begin
         active_prev <= active_vec;
      end
   end

   // ----------------------------------------------------------------------------
   // Latched alarm flags
   // ----------------------------------------------------------------------------
   // A status read clears them; a still-present condition sets them again
   assign trip_clear = take_rd && (word_adr == aar_pkg::ALARM_STATUS_OFS) ? '1 : '0;

   // Set wins, so a read never hides a live alarm
   aar_flag #(
      .WIDTH   (NF)
   ) u_tripped (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (active_vec),
      .clear_i (trip_clear),
      .flag_o  (tripped)
   );

   // ----------------------------------------------------------------------------
   // Interrupt status: one event per new alarm onset
   // ----------------------------------------------------------------------------
   // Onset only: a held condition raises one event, not one per cycle
   assign irq_set   = active_vec & ~active_prev;
   assign irq_clear = take_wr && (word_adr == aar_pkg::IRQ_CLEAR_OFS) ? wb_dat_i[NF-1:0] : '0;

   // Write-one clear; an onset in the same cycle still lands
   aar_flag #(
      .WIDTH   (NF)
   ) u_irq_status (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (irq_set),
      .clear_i (irq_clear),
      .flag_o  (irq_status)
   );

   // ----------------------------------------------------------------------------
   // Wishbone request decode
   // ----------------------------------------------------------------------------
   // One request per ack; the gap after ack keeps a held strobe from double-firing
   assign take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign take_wr  = take && wb_we_i;
   assign take_rd  = take && !wb_we_i;
   assign word_adr = {wb_adr_i[ADDR_W-1:2], 2'b00};

   // ----------------------------------------------------------------------------
   // Alarm status word
   // ----------------------------------------------------------------------------
   // Reserved positions stay zero; nothing here is writable
   always_comb begin
      status_word                               = aar_pkg::STATUS_RST;
      status_word[aar_pkg::ACT_SUPPLY_LOW_BIT]  = act_supply_low;
      status_word[aar_pkg::ACT_SUPPLY_HIGH_BIT] = act_supply_high;
      status_word[aar_pkg::ACT_INPUT_LOW_BIT]   = act_input_low;
      status_word[aar_pkg::ACT_INPUT_HIGH_BIT]  = act_input_high;
      status_word[aar_pkg::LAT_SUPPLY_LOW_BIT]  = tripped[aar_pkg::FLAG_SUPPLY_LOW];
      status_word[aar_pkg::LAT_SUPPLY_HIGH_BIT] = tripped[aar_pkg::FLAG_SUPPLY_HIGH];
      status_word[aar_pkg::LAT_INPUT_LOW_BIT]   = tripped[aar_pkg::FLAG_INPUT_LOW];
      status_word[aar_pkg::LAT_INPUT_HIGH_BIT]  = tripped[aar_pkg::FLAG_INPUT_HIGH];
      status_word[aar_pkg::OVERALL_BIT]         = |tripped;
   end

   // ----------------------------------------------------------------------------
   // Writable registers with byte lanes
   // ----------------------------------------------------------------------------
   // Host must keep threshold nibbles zero; stored as written, ignored in compare
   always_comb begin
      next_hyst_byte  = hyst_byte;
      next_high_th    = high_th;
      next_low_th     = low_th;
      next_irq_enable = irq_enable;
      if (take_wr) begin
         unique case (word_adr)
            aar_pkg::HIGH_TH_OFS: begin
               if (wb_sel_i[0]) begin
                  next_high_th[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_high_th[15:8] = wb_dat_i[15:8];
               end
               if (wb_sel_i[3]) begin
                  next_hyst_byte = wb_dat_i[31:aar_pkg::HYST_LSB];
               end
            end
            aar_pkg::LOW_TH_OFS: begin
               if (wb_sel_i[0]) begin
                  next_low_th[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_low_th[15:8] = wb_dat_i[15:8];
               end
            end
            aar_pkg::IRQ_ENABLE_OFS: begin
               if (wb_sel_i[0]) begin
                  next_irq_enable = wb_dat_i[NF-1:0];
               end
            end
            default: begin
               next_irq_enable = irq_enable;
            end
         endcase
      end
   end

   // Window comes up fully open: high at top, low at bottom
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hyst_byte  <= aar_pkg::HYST_RST;
         high_th    <= aar_pkg::HIGH_TH_RST;
         low_th     <= aar_pkg::LOW_TH_RST;
         irq_enable <= '0;
      end else begin
         hyst_byte  <= next_hyst_byte;
         high_th    <= next_high_th;
         low_th     <= next_low_th;
         irq_enable <= next_irq_enable;
      end
   end

   // ----------------------------------------------------------------------------
   // Read data and acknowledge
   // ----------------------------------------------------------------------------
   // Unmapped and write-only words read zero but are still acknowledged,
   // so a stray access never hangs the bus
   always_comb begin
      next_ack = take;
      next_dat = 32'h0000_0000;
      if (take_rd) begin
         unique case (word_adr)
            aar_pkg::ALARM_STATUS_OFS: begin
               next_dat = status_word;
            end
            aar_pkg::HIGH_TH_OFS: begin
               next_dat = {hyst_byte, 8'h00, high_th};
            end
            aar_pkg::LOW_TH_OFS: begin
               next_dat = {16'h0000, low_th};
            end
            aar_pkg::IRQ_STATUS_OFS: begin
               next_dat[NF-1:0] = irq_status;
            end
            aar_pkg::IRQ_ENABLE_OFS: begin
               next_dat[NF-1:0] = irq_enable;
            end
            default: begin
               next_dat = 32'h0000_0000;
            end
         endcase
      end
   end

   // Ack and data leave from flops; data idles at zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ----------------------------------------------------------------------------
   // Registered alarm and interrupt outputs
   // ----------------------------------------------------------------------------
   // One cycle behind the flags, traded for a clean flop-driven pin
   always_comb begin
      next_overall = |tripped;
      next_irq     = |(irq_status & irq_enable);
   end

   // Both pins drop with reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overall_alarm_o <= 1'b0;
         irq_o           <= 1'b0;
      end else begin
         overall_alarm_o <= next_overall;
         irq_o           <= next_irq;
      end
   end

endmodule : aar_top

`default_nettype wire

// ---- tb/aar_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------
// Port checker for the alarm register bank
// ----------
module aar_top_chk #(
   parameter int ADDR_W = 8,
   parameter int CODE_W = 12
) (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic [CODE_W-1:0] conv_data_i,
   input wire logic              conv_valid_i,
   input wire logic              supply_low_i,
   input wire logic              supply_high_i,
   input wire logic              overall_alarm_o,
   input wire logic              irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Request taken only while no ack is out
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(w);
      s_req ##0 (!wb_we_i && wb_adr_i[7:2] == w);
   endsequence
   // Pin held long enough to pass the synchroniser
   sequence s_supply_low;
      supply_low_i [*4];
   endsequence

   a_ack_next_cycle: assert property (s_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_status_reserved: assert property (s_rd(6'h08) |=> (wb_dat_o & 32'hffff_330e) == 32'h0)
      else $error("status reserved bits not zero");
   a_summary_or_bit: assert property (s_rd(6'h08) |=> wb_dat_o[0] == |wb_dat_o[7:4])
      else $error("summary bit not OR of tripped flags");
   a_high_reserved: assert property (s_rd(6'h09) |=> wb_dat_o[23:16] == 8'h00)
      else $error("high threshold reserved byte not zero");
   a_low_reserved: assert property (s_rd(6'h0a) |=> wb_dat_o[31:16] == 16'h0000)
      else $error("low threshold upper half not zero");
   a_supply_low_trips: assert property (s_supply_low |-> ##[0:3] overall_alarm_o)
      else $error("supply low did not raise alarm");
endmodule : aar_top_chk

bind aar_top aar_top_chk #(.ADDR_W(ADDR_W), .CODE_W(CODE_W)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_data_i(conv_data_i),
   .conv_valid_i(conv_valid_i), .supply_low_i(supply_low_i), .supply_high_i(supply_high_i),
   .overall_alarm_o(overall_alarm_o), .irq_o(irq_o));

`default_nettype wire

// ---- tb/aar_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------
// Host controller: classic Wishbone master
// ----------
module aar_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   output var  logic        cyc_o,
   output var  logic        stb_o,
   output var  logic        we_o,
   output var  logic [7:0]  adr_o,
   output var  logic [3:0]  sel_o,
   output var  logic [31:0] dat_o
);
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
   end

   // One cycle; no latency assumed, the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a; // Released lines show no stale copy
      dat_o <= ~d;
      @(posedge clk_i);
   endtask : xfer
endmodule : aar_host

`default_nettype wire

// ---- tb/adc_alarm_registers_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_alarm_registers_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic        conv_valid_i = 1'b0;
   logic        supply_low_i = 1'b0;
   logic        supply_high_i = 1'b0;
   logic        overall_alarm_o, irq_o;
   logic [11:0] conv_data_i = 12'h000;
   int          err_total = 0;
   int          checked = 0;
   logic [31:0] exp_q[$];
   // Codes around both thresholds with hysteresis 3
   logic [11:0] codes[10] = '{12'h800, 12'h801, 12'h7fe, 12'h7fd, 12'h7fd,
                              12'h100, 12'h0ff, 12'h102, 12'h103, 12'h103};
   logic [15:0] stat[10] = '{16'h0, 16'h411, 16'h411, 16'h11, 16'h0,
                             16'h0, 16'h821, 16'h821, 16'h21, 16'h0};

   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   aar_top DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_data_i(conv_data_i),
      .conv_valid_i(conv_valid_i), .supply_low_i(supply_low_i), .supply_high_i(supply_high_i),
      .overall_alarm_o(overall_alarm_o), .irq_o(irq_o));

   aar_host u_host (
      .clk_i(clk_i), .ack_i(wb_ack_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
      .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

   // ----------
   // Compare and report
   // ----------
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic cmp_pin(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_pin

   task automatic summarize;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // Read note goes in the queue before the cycle starts
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b0, a, 32'h0, 4'hf);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wr_lane(a, d, 4'hf);
   endtask : wr

   // Byte-lane write; unselected lanes keep their contents
   task automatic wr_lane(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      u_host.xfer(1'b1, a, d, s);
   endtask : wr_lane

   // One conversion pulse, then let flags settle
   task automatic conv(input logic [11:0] c);
      conv_data_i  <= c;
      conv_valid_i <= 1'b1;
      @(posedge clk_i);
      conv_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : conv

   // Oldest note checked against each read ack
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         cmp("read data", exp_q.pop_front(), wb_dat_o);
      end
   end

   // Watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      summarize();
   end

   // ----------
   // Main sequence
   // ----------
   initial begin : main
      int i;
      r = $urandom(32'h6476);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h0000_ffff);
      rd(8'h28, 32'h0);
      rd(8'h2c, 32'h0);
      rd(8'h38, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0);
      // Host keeps unused low bits zero; reserved byte gets noise
      for (i = 0; i < 4; i++) begin
         r = $urandom & 32'hc0ff_fff0;
         wr(8'h24, r);
         rd(8'h24, r & 32'hff00_ffff);
         wr(8'h28, r);
         rd(8'h28, r & 32'h0000_ffff);
      end
      wr(8'h24, 32'hc000_8000);
      wr(8'h28, 32'h0000_1000);
      wr(8'h38, 32'h0000_000f);
      rd(8'h38, 32'h0000_000f);
      for (i = 0; i < 10; i++) begin
         conv(codes[i]);
         rd(8'h20, {16'h0, stat[i]});
      end
      cmp_pin("irq", 1'b1, irq_o);
      cmp_pin("overall", 1'b0, overall_alarm_o);
      rd(8'h30, 32'h3);
      wr(8'h34, 32'h3);
      rd(8'h30, 32'h0);
      cmp_pin("irq", 1'b0, irq_o);
      // Supply alarms with the interrupt masked
      wr(8'h38, 32'h0);
      for (i = 0; i < 2; i++) begin
         {supply_low_i, supply_high_i} <= (i == 0) ? 2'b10 : 2'b01;
         repeat (5) @(posedge clk_i);
         cmp_pin("overall", 1'b1, overall_alarm_o);
         rd(8'h20, (i == 0) ? 32'h8081 : 32'h4041);
         {supply_low_i, supply_high_i} <= 2'b00;
         repeat (5) @(posedge clk_i);
         rd(8'h20, (i == 0) ? 32'h0081 : 32'h0041);
         rd(8'h20, 32'h0);
      end
      cmp_pin("irq", 1'b0, irq_o);
      rd(8'h30, 32'hc);
      wr(8'h38, 32'h4);
      repeat (2) @(posedge clk_i);
      cmp_pin("irq", 1'b1, irq_o);
      wr(8'h34, 32'hc);
      repeat (2) @(posedge clk_i);
      cmp_pin("irq", 1'b0, irq_o);
      // Lane writes: only the selected bytes move
      wr_lane(8'h24, 32'h3f3f_3f30, 4'h1);
      rd(8'h24, 32'hc000_8030);
      wr_lane(8'h24, 32'h4000_ffff, 4'h8);
      rd(8'h24, 32'h4000_8030);
      wr_lane(8'h28, 32'h0000_2a00, 4'h2);
      rd(8'h28, 32'h0000_2a00);
      summarize();
   end
endmodule : adc_alarm_registers_tb

`default_nettype wire
